//--- hw/cbs_defs.vh
// Constants for the bus cycle sequencer: operation codes, cycle counts, fixed addresses
`ifndef CBS_DEFS_VH
`define CBS_DEFS_VH

// ------------------------------------------------------------
// Operation codes on the OP port
// ------------------------------------------------------------
`define CBS_OP_WAIT 3'h0
`define CBS_OP_MUL 3'h1
`define CBS_OP_RTI 3'h2
`define CBS_OP_SWI 3'h3
`define CBS_OP_BSR 3'h4
`define CBS_OP_BR 3'h5

// ------------------------------------------------------------
// Length of each sequence in bus cycles
// ------------------------------------------------------------
`define CBS_LEN_WAIT 4'h9
`define CBS_LEN_MUL 4'hA
`define CBS_LEN_RTI 4'hA
`define CBS_LEN_SWI 4'hC
`define CBS_LEN_BSR 4'h6
`define CBS_LEN_BR 4'h3

// ------------------------------------------------------------
// Fixed addresses and offsets
// ------------------------------------------------------------
`define CBS_ADDR_IDLE 16'hFFFF
`define CBS_ADDR_VEC_HI 16'hFFFA
`define CBS_ADDR_VEC_LO 16'hFFFB
`define CBS_STACK_FRAME 16'h0007
`define CBS_BSR_SP_DROP 16'h0002
`define CBS_STACK_BASE_CYC 4'h3

`endif

//--- hw/cbs_seq.v
// Bus cycle sequencer for wait, multiply, interrupt return/entry and relative branches
// Notes on behaviour
// (RL1) Wait cycles 5-9 write X low, X high, A, B, CC at SP-2 down to SP-6.
// (RL2) Halted in wait, repeat reads at original SP minus seven.
// (RL3) Halted in wait, address and read/write keep driving; the data output enable stays off.
// (RL4) Internal cycles are dummy reads of FFFF: multiply 3-10, branch cycle 3.
// (RL5) Return-from-interrupt: fetch, PC+1, SP, then CC,B,A,XH,XL from SP+1..+5.
// (RL6) Return cycles 9,10 read resume PC high at SP+6, low at SP+7.
// (RL7) Software interrupt: 12 cycles, writes PC lo/hi, X lo/hi, A, B, CC at SP..SP-6.
// (RL8) Software interrupt cycle 10 dummy read SP-7, then vector FFFA, FFFB.
// (RL9) Subroutine branch: fetch, offset, dummy, target fetch, return lo at SP, hi SP-1.
// (RL10) Read/write low only in stacking writes; high on every other cycle.
`timescale 1ns/100ps
`default_nettype none
`include "cbs_defs.vh"

module cbs_seq (
  // Clock and reset
  input wire CLK,
  input wire NRST,
  // Instruction request
  input wire START,
  input wire [2:0] OP,
  input wire BR_TAKEN,
  input wire WAKE,
  // Register state at instruction start
  input wire [15:0] PC_IN,
  input wire [15:0] SP_IN,
  input wire [15:0] X_IN,
  input wire [7:0] A_IN,
  input wire [7:0] B_IN,
  input wire [7:0] CC_IN,
  // Memory bus
  input wire [7:0] DATA_IN,
  output reg [15:0] ADDR,
  output reg RW,
  output reg [7:0] DATA_OUT,
  output reg DATA_OE_N,
  // Status and results
  output reg BUSY,
  output reg HALTED,
  output reg DONE,
  output reg [15:0] NEXT_PC,
  output reg [15:0] SP_OUT,
  output reg [15:0] X_OUT,
  output reg [7:0] A_OUT,
  output reg [7:0] B_OUT,
  output reg [7:0] CC_OUT
);

  // ------------------------------------------------------------
  // States
  // ------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_HALT = 2'h2;

  reg [1:0] state_q;
  reg [3:0] cyc_q;
  reg [2:0] op_q;
  reg [15:0] pc_q, sp_q, x_q, tgt_q, prod_q;
  reg [7:0] a_q, b_q, cc_q, hi_q;

  // ------------------------------------------------------------
  // Bus cycle tables
  // ------------------------------------------------------------
  // Sequence length per operation
  function [3:0] seq_len(input [2:0] op);
    begin
      case (op)
        `CBS_OP_WAIT: seq_len = `CBS_LEN_WAIT;
        `CBS_OP_MUL: seq_len = `CBS_LEN_MUL;
        `CBS_OP_RTI: seq_len = `CBS_LEN_RTI;
        `CBS_OP_SWI: seq_len = `CBS_LEN_SWI;
        `CBS_OP_BSR: seq_len = `CBS_LEN_BSR;
        default: seq_len = `CBS_LEN_BR;
      endcase
    end
  endfunction

  // True for cycles that push onto the stack
  function is_write(input [2:0] op, input [3:0] c);
    begin
      // (RL10) write only when stacking
      case (op)
        `CBS_OP_WAIT: is_write = (c >= 4'h3) && (c <= 4'h9);
        `CBS_OP_SWI: is_write = (c >= 4'h3) && (c <= 4'h9);
        `CBS_OP_BSR: is_write = (c == 4'h5) || (c == 4'h6);
        default: is_write = 1'b0;
      endcase
    end
  endfunction

  // Address presented in cycle c; fetch and operand byte lead every sequence
  function [15:0] bus_addr(input [2:0] op, input [3:0] c, input [15:0] pc, input [15:0] sp,
    input [15:0] tgt);
    reg [15:0] k;
    begin
      k = {12'h000, c - `CBS_STACK_BASE_CYC};
      case (op)
        // (RL1) stack walk down
        `CBS_OP_WAIT: bus_addr = sp - k;
        // (RL7) (RL8) stack walk down, then vector
        `CBS_OP_SWI: bus_addr = (c == 4'hB) ? `CBS_ADDR_VEC_HI :
          ((c == 4'hC) ? `CBS_ADDR_VEC_LO : (sp - k));
        // (RL5) (RL6) stack walk up
        `CBS_OP_RTI: bus_addr = sp + k;
        // (RL9) target fetch, then return push
        `CBS_OP_BSR: bus_addr = (c == 4'h4) ? tgt : ((c == 4'h5) ? sp :
          ((c == 4'h6) ? (sp - 16'h0001) : `CBS_ADDR_IDLE));
        // (RL4) internal dummy reads
        default: bus_addr = `CBS_ADDR_IDLE;
      endcase
      if (c == 4'h1) begin
        bus_addr = pc;
      end else if (c == 4'h2) begin
        bus_addr = pc + 16'h0001;
      end
    end
  endfunction

  // Byte driven on writes
  function [7:0] bus_data(input [2:0] op, input [3:0] c, input [15:0] ret, input [15:0] x,
    input [7:0] a, input [7:0] b, input [7:0] cc);
    begin
      case (c)
        4'h3: bus_data = ret[7:0];
        4'h4: bus_data = ret[15:8];
        4'h5: bus_data = (op == `CBS_OP_BSR) ? ret[7:0] : x[7:0];
        4'h6: bus_data = (op == `CBS_OP_BSR) ? ret[15:8] : x[15:8];
        4'h7: bus_data = a;
        4'h8: bus_data = b;
        4'h9: bus_data = cc;
        default: bus_data = 8'h00;
      endcase
    end
  endfunction

  // Return address pushed by the operation
  wire [15:0] ret_addr = (op_q == `CBS_OP_BSR) ? (pc_q + 16'h0002) : (pc_q + 16'h0001);
  wire [3:0] cyc_nx = cyc_q + 4'h1;
  wire wr_nx = is_write(op_q, cyc_nx);
  wire last_cyc = (cyc_q == seq_len(op_q));
  wire [15:0] tgt_calc = pc_q + 16'h0002 + {{8{DATA_IN[7]}}, DATA_IN};

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  // One bus cycle per clock; bus outputs are set for the cycle being entered
  always @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      state_q <= ST_IDLE;
      cyc_q <= 4'h0;
      op_q <= 3'h0;
      pc_q <= 16'h0000;
      sp_q <= 16'h0000;
      x_q <= 16'h0000;
      a_q <= 8'h00;
      b_q <= 8'h00;
      cc_q <= 8'h00;
      tgt_q <= 16'h0000;
      hi_q <= 8'h00;
      prod_q <= 16'h0000;
      ADDR <= `CBS_ADDR_IDLE;
      RW <= 1'b1;
      DATA_OUT <= 8'h00;
      DATA_OE_N <= 1'b1;
      BUSY <= 1'b0;
      HALTED <= 1'b0;
      DONE <= 1'b0;
      NEXT_PC <= 16'h0000;
      SP_OUT <= 16'h0000;
      X_OUT <= 16'h0000;
      A_OUT <= 8'h00;
      B_OUT <= 8'h00;
      CC_OUT <= 8'h00;
    end else begin
      DONE <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          ADDR <= `CBS_ADDR_IDLE;
          RW <= 1'b1;
          DATA_OE_N <= 1'b1;
          if (START) begin
            state_q <= ST_RUN;
            cyc_q <= 4'h1;
            op_q <= OP;
            pc_q <= PC_IN;
            sp_q <= SP_IN;
            x_q <= X_IN;
            a_q <= A_IN;
            b_q <= B_IN;
            cc_q <= CC_IN;
            prod_q <= {8'h00, A_IN} * {8'h00, B_IN};
            ADDR <= PC_IN;
            BUSY <= 1'b1;
          end
        end
        ST_RUN: begin
          // Capture read data of the cycle now ending
          if (cyc_q == 4'h2) begin
            tgt_q <= tgt_calc;
          end
          if (op_q == `CBS_OP_RTI) begin
            // (RL5) restore registers from stack
            case (cyc_q)
              4'h4: cc_q <= DATA_IN;
              4'h5: b_q <= DATA_IN;
              4'h6: a_q <= DATA_IN;
              4'h7: x_q[15:8] <= DATA_IN;
              4'h8: x_q[7:0] <= DATA_IN;
              4'h9: hi_q <= DATA_IN;
              default: hi_q <= hi_q;
            endcase
          end
          if ((op_q == `CBS_OP_SWI) && (cyc_q == 4'hB)) begin
            hi_q <= DATA_IN;
          end
          if (last_cyc && (op_q == `CBS_OP_WAIT)) begin
            // (RL2) (RL3) halt with bus still driven, repeating reads
            state_q <= ST_HALT;
            HALTED <= 1'b1;
            ADDR <= sp_q - `CBS_STACK_FRAME;
            RW <= 1'b1;
            DATA_OE_N <= 1'b1;
            DATA_OUT <= 8'h00;
          end else if (last_cyc) begin
            state_q <= ST_IDLE;
            BUSY <= 1'b0;
            DONE <= 1'b1;
            ADDR <= `CBS_ADDR_IDLE;
            RW <= 1'b1;
            DATA_OE_N <= 1'b1;
            DATA_OUT <= 8'h00;
            X_OUT <= x_q;
            A_OUT <= a_q;
            B_OUT <= b_q;
            CC_OUT <= cc_q;
            SP_OUT <= sp_q;
            NEXT_PC <= pc_q + 16'h0002;
            case (op_q)
              `CBS_OP_MUL: begin
                A_OUT <= prod_q[15:8];
                B_OUT <= prod_q[7:0];
                NEXT_PC <= pc_q + 16'h0001;
              end
              // (RL6) resume from restored address
              `CBS_OP_RTI: begin
                NEXT_PC <= {hi_q, DATA_IN};
                SP_OUT <= sp_q + `CBS_STACK_FRAME;
              end
              // (RL8) jump through vector
              `CBS_OP_SWI: begin
                NEXT_PC <= {hi_q, DATA_IN};
                SP_OUT <= sp_q - `CBS_STACK_FRAME;
              end
              `CBS_OP_BSR: begin
                NEXT_PC <= tgt_q;
                SP_OUT <= sp_q - `CBS_BSR_SP_DROP;
              end
              `CBS_OP_BR: NEXT_PC <= BR_TAKEN ? tgt_q : (pc_q + 16'h0002);
              default: NEXT_PC <= pc_q + 16'h0002;
            endcase
          end else begin
            cyc_q <= cyc_nx;
            ADDR <= bus_addr(op_q, cyc_nx, pc_q, sp_q, tgt_q); // Target held from offset cycle
            // (RL10) direction and data follow stacking writes only
            RW <= ~wr_nx;
            DATA_OE_N <= ~wr_nx;
            DATA_OUT <= wr_nx ? bus_data(op_q, cyc_nx, ret_addr, x_q, a_q, b_q, cc_q) : 8'h00;
          end
        end
        ST_HALT: begin
          // (RL2) reads continue until woken; the vector fetch lies outside
          ADDR <= sp_q - `CBS_STACK_FRAME;
          RW <= 1'b1;
          if (WAKE) begin
            state_q <= ST_IDLE;
            HALTED <= 1'b0;
            BUSY <= 1'b0;
            DONE <= 1'b1;
            SP_OUT <= sp_q - `CBS_STACK_FRAME;
            NEXT_PC <= pc_q + 16'h0001;
            X_OUT <= x_q;
            A_OUT <= a_q;
            B_OUT <= b_q;
            CC_OUT <= cc_q;
            ADDR <= `CBS_ADDR_IDLE;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

endmodule
`default_nettype wire

//--- dv/cbs_mem.sv
// Memory partner answering every read with an address-derived byte
`timescale 1ns/100ps
`default_nettype none
module cbs_mem (
  // Bus from the sequencer
  input wire logic [15:0] addr,
  input wire logic rw,
  // Read data back
  output logic [7:0] rdata
);
  // Inverse pattern on writes so a stale byte is never mistaken for read data
  assign rdata = rw ? (addr[15:8] ^ addr[7:0]) : ~(addr[15:8] ^ addr[7:0]);
endmodule
`default_nettype wire

//--- dv/cbs_seq_assertions.sv
// Bus cycle checker for the sequencer ports
`timescale 1ns/100ps
`default_nettype none
`include "cbs_defs.vh"
module cbs_seq_chk (
  // Clock, reset, request
  input wire logic CLK,
  input wire logic NRST,
  input wire logic START,
  input wire logic [2:0] OP,
  input wire logic [15:0] SP_IN,
  // Bus and status
  input wire logic [15:0] ADDR,
  input wire logic RW,
  input wire logic [7:0] DATA_OUT,
  input wire logic DATA_OE_N,
  input wire logic BUSY,
  input wire logic HALTED,
  input wire logic DONE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic [15:0] sp_q;
  logic tk;
  assign tk = START && !BUSY;
  // Keep the stack pointer of the accepted request; refused requests leave it alone
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) sp_q <= 16'h0000;
    else if (tk) sp_q <= SP_IN;
  end
  property p_oe_rw; RW == DATA_OE_N; endproperty
  a_oe_rw: assert property (p_oe_rw) else $error("data enable differs from write");
  property p_rd_zero; RW |-> DATA_OUT == 8'h00; endproperty
  a_rd_zero: assert property (p_rd_zero) else $error("write data seen on read");
  property p_halt; HALTED |-> RW && DATA_OE_N && ADDR == sp_q - 16'h0007; endproperty
  a_halt: assert property (p_halt) else $error("halt read address wrong");
  property p_wait;
    tk && OP == `CBS_OP_WAIT |=> ##4 (!RW && ADDR == sp_q - 16'h0002)
      ##4 (!RW && ADDR == sp_q - 16'h0006) ##1 HALTED;
  endproperty
  a_wait: assert property (p_wait) else $error("wait stacking wrong");
  property p_mul; tk && OP == `CBS_OP_MUL |=> ##2 (ADDR == 16'hFFFF && RW) [*8] ##1 DONE; endproperty
  a_mul: assert property (p_mul) else $error("multiply idle cycles wrong");
  property p_br; tk && OP == `CBS_OP_BR |=> ##2 (ADDR == 16'hFFFF && RW) ##1 DONE; endproperty
  a_br: assert property (p_br) else $error("branch idle cycle wrong");
  property p_rti;
    tk && OP == `CBS_OP_RTI |=> ##2 (RW && ADDR == sp_q)
      ##7 (RW && ADDR == sp_q + 16'h0007) ##1 DONE;
  endproperty
  a_rti: assert property (p_rti) else $error("return sequence wrong");
  property p_swi;
    tk && OP == `CBS_OP_SWI |=> ##9 (RW && ADDR == sp_q - 16'h0007)
      ##1 (RW && ADDR == 16'hFFFA) ##1 (RW && ADDR == 16'hFFFB) ##1 DONE;
  endproperty
  a_swi: assert property (p_swi) else $error("interrupt entry tail wrong");
  property p_bsr;
    tk && OP == `CBS_OP_BSR |=> ##4 (!RW && ADDR == sp_q)
      ##1 (!RW && ADDR == sp_q - 16'h0001) ##1 DONE;
  endproperty
  a_bsr: assert property (p_bsr) else $error("subroutine stacking wrong");
endmodule
`default_nettype wire

//--- dv/cbs_seq_tb.sv
// Self-checking bench for the bus cycle sequencer
`timescale 1ns/100ps
`default_nettype none
`include "cbs_defs.vh"
module cbs_seq_tb;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic start = 1'b0;
  logic wake = 1'b0;
  logic brt = 1'b0;
  logic [2:0] op = 3'h0;
  logic [15:0] pc = 16'h0000, sp = 16'h0000, x = 16'h0000;
  logic [7:0] a = 8'h00, b = 8'h00, cc = 8'h00;
  wire [15:0] addr, npc, spo, xo;
  wire [7:0] din, dout, ao, bo, cco;
  wire rw, oe_n, busy, halted, done;
  int err_total = 0;
  int samples_checked = 0;
  logic [3:0] rows [0:6];
  always #2.5 clk = ~clk;
  cbs_seq i_cbs_seq (.CLK(clk), .NRST(nrst), .START(start), .OP(op), .BR_TAKEN(brt),
    .WAKE(wake), .PC_IN(pc), .SP_IN(sp), .X_IN(x), .A_IN(a), .B_IN(b), .CC_IN(cc),
    .DATA_IN(din), .ADDR(addr), .RW(rw), .DATA_OUT(dout), .DATA_OE_N(oe_n), .BUSY(busy),
    .HALTED(halted), .DONE(done), .NEXT_PC(npc), .SP_OUT(spo), .X_OUT(xo), .A_OUT(ao),
    .B_OUT(bo), .CC_OUT(cco));
  cbs_mem i_cbs_mem (.addr(addr), .rw(rw), .rdata(din));
  // ----------------------------------------
  // Expected bus cycles
  // ----------------------------------------
  function logic [7:0] f(input logic [15:0] ad);
    return ad[15:8] ^ ad[7:0];
  endfunction
  function logic [15:0] tgt();
    logic [7:0] d;
    d = f(pc + 16'h0001);
    return pc + 16'h0002 + {{8{d[7]}}, d};
  endfunction
  // Returns {rw, address, write data} for cycle c
  function logic [24:0] ex(input logic [2:0] o, input logic [3:0] c);
    logic [15:0] r1;
    logic [7:0] w [0:6];
    r1 = pc + 16'h0001;
    w = '{r1[7:0], r1[15:8], x[7:0], x[15:8], a, b, cc};
    if (c == 4'h1) return {1'b1, pc, 8'h00};
    if (c == 4'h2) return {1'b1, r1, 8'h00};
    case (o)
      `CBS_OP_WAIT, `CBS_OP_SWI:
        if (c <= 4'h9) return {1'b0, sp - 16'(c - 4'h3), w[c - 4'h3]};
        else if (c == 4'hA) return {1'b1, sp - 16'h0007, 8'h00};
        else return {1'b1, 16'hFFF9 + 16'(c - 4'hA), 8'h00};
      `CBS_OP_RTI: return {1'b1, sp + 16'(c - 4'h3), 8'h00};
      `CBS_OP_BSR:
        if (c == 4'h4) return {1'b1, tgt(), 8'h00};
        else if (c == 4'h5) return {1'b0, sp, r1[7:0] + 8'h01};
        else if (c == 4'h6) return {1'b0, sp - 16'h0001, 8'(16'(pc + 16'h0002) >> 8)};
        else return {1'b1, 16'hFFFF, 8'h00};
      default: return {1'b1, 16'hFFFF, 8'h00};
    endcase
  endfunction
  function logic [15:0] np(input logic [2:0] o);
    case (o)
      `CBS_OP_SWI: return {f(16'hFFFA), f(16'hFFFB)};
      `CBS_OP_RTI: return {f(sp + 16'h0006), f(sp + 16'h0007)};
      `CBS_OP_BSR: return tgt();
      `CBS_OP_BR: return brt ? tgt() : pc + 16'h0002;
      default: return pc + 16'h0001;
    endcase
  endfunction
  function logic [3:0] len(input logic [2:0] o);
    case (o)
      `CBS_OP_WAIT: return `CBS_LEN_WAIT;
      `CBS_OP_MUL: return `CBS_LEN_MUL;
      `CBS_OP_RTI: return `CBS_LEN_RTI;
      `CBS_OP_SWI: return `CBS_LEN_SWI;
      `CBS_OP_BSR: return `CBS_LEN_BSR;
      default: return `CBS_LEN_BR;
    endcase
  endfunction
  task ck(input string n, input logic [31:0] e, input logic [31:0] s);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task complete_run;
    if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // One whole operation; a second start in cycle 4 (not driven for the three-cycle branch) must be ignored while busy
  task run(input logic [2:0] o, input logic t);
    logic [24:0] e;
    int k;
    op = o;
    brt = t;
    start = 1'b1;
    @(negedge clk);
    for (int c = 1; c <= len(o); c++) begin
      start = (c == 4);
      e = ex(o, 4'(c));
      ck("addr", {16'h0, e[23:8]}, {16'h0, addr});
      ck("rw", {31'h0, e[24]}, {31'h0, rw});
      ck("dout", {24'h0, e[7:0]}, {24'h0, dout});
      @(negedge clk);
    end
    if (o == `CBS_OP_WAIT) begin
      repeat (3) begin
        ck("halt_addr", {16'h0, sp - 16'h0007}, {16'h0, addr});
        ck("halted", 32'h1, {31'h0, halted});
        @(negedge clk);
      end
      wake = 1'b1;
      k = 0;
      while (done !== 1'b1 && k < 4) begin
        @(negedge clk);
        k++;
      end
      wake = 1'b0;
    end
    ck("done", 32'h1, {31'h0, done});
    ck("next_pc", {16'h0, np(o)}, {16'h0, npc});
    if (o == `CBS_OP_MUL) ck("product", {16'h0, 16'(a) * 16'(b)}, {16'h0, ao, bo});
    if (o == `CBS_OP_RTI) ck("x_out", {16'h0, f(sp + 16'h4), f(sp + 16'h5)}, {16'h0, xo});
    if (o == `CBS_OP_SWI) ck("sp_out", {16'h0, sp - 16'h0007}, {16'h0, spo});
    if (o == `CBS_OP_WAIT) ck("sp_out", {16'h0, sp - 16'h0007}, {16'h0, spo});
    if (o == `CBS_OP_RTI) ck("sp_out", {16'h0, sp + 16'h0007}, {16'h0, spo});
    if (o == `CBS_OP_BSR) ck("sp_out", {16'h0, sp - 16'h0002}, {16'h0, spo});
    if (o == `CBS_OP_RTI) ck("cc_out", {24'h0, f(sp + 16'h0001)}, {24'h0, cco});
    if (o == `CBS_OP_RTI) ck("b_a_out", {16'h0, f(sp + 16'h2), f(sp + 16'h3)}, {16'h0, bo, ao});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rows = '{{`CBS_OP_WAIT, 1'b0}, {`CBS_OP_MUL, 1'b0}, {`CBS_OP_RTI, 1'b0},
      {`CBS_OP_SWI, 1'b0}, {`CBS_OP_BSR, 1'b0}, {`CBS_OP_BR, 1'b1}, {`CBS_OP_BR, 1'b0}};
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    // Row 0 puts the stack near zero so the wait frame wraps
    for (int i = 0; i < 7; i++) begin
      pc = 16'h7FF0 + 16'(i * 16'h1111);
      sp = 16'h0003 + 16'(i * 16'h2000);
      x = 16'hA55A ^ pc;
      a = 8'hFF - 8'(i);
      b = 8'hFE;
      cc = 8'hC0 + 8'(i);
      run(rows[i][3:1], rows[i][0]);
      @(negedge clk);
    end
    // Reset in mid-multiply must return the bus to idle at once
    op = `CBS_OP_MUL;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    repeat (3) @(negedge clk);
    nrst = 1'b0;
    #1;
    ck("reset_bus", {13'h0, 16'hFFFF, 3'b110}, {13'h0, addr, rw, oe_n, busy});
    @(negedge clk);
    nrst = 1'b1;
    run(`CBS_OP_BR, 1'b0);
    complete_run;
  end
  // Watchdog well beyond the expected run length
  initial begin
    #5000;
    err_total++;
    complete_run;
  end
endmodule
bind cbs_seq cbs_seq_chk i_cbs_seq_chk (.CLK(CLK), .NRST(NRST), .START(START), .OP(OP),
  .SP_IN(SP_IN), .ADDR(ADDR), .RW(RW), .DATA_OUT(DATA_OUT), .DATA_OE_N(DATA_OE_N),
  .BUSY(BUSY), .HALTED(HALTED), .DONE(DONE));
`default_nettype wire
